// File: sflash_regs.vh
// Purpose: constants for the serial flash command core
// Assumes: included by serial_flash_command_core.v
// Notes: offsets are byte addresses on the register port
`ifndef SFLASH_REGS_VH
`define SFLASH_REGS_VH
`define OFF_CTRL 8'h00
`define OFF_STAT 8'h04
`define OFF_PEEK 8'h08
`define OFF_DATA 8'h0C
`define CTRL_RST 9'h008
`define F_PG512 4
`define F_FPROG 5
`define F_FERASE 6
`define F_FREEZE 7
`define F_LOCK 8
`define ST_INPROG 0
`define ST_WLATCH 1
`define ST_EERR 5
`define ST_PERR 6
`define STATUS1_READ_CMD 8'h05
`define ANY_REGISTER_READ_CMD 8'h65
`define STATUS_CLEAR_CMD 8'h30
`define STATUS_CLEAR_ALT 8'h82
`define RESET_ARM_CMD 8'h66
`define RESET_GO_CMD 8'h99
`define RESET_LEGACY_CMD 8'hF0
`define MODE_BITS_CLEAR_CMD 8'hFF
`define DEEP_SLEEP_CMD 8'hB9
`define WAKE_CMD 8'hAB
`define WRITE_LOCK_CMD 8'h04
`define WRITE_UNLOCK_CMD 8'h06
`define PAGE_WRITE_CMD 8'h02
`define REG_WRITE_CMD 8'h01
`define ERASE_PARAM_CMD 8'h20
`define ERASE_SECTOR_CMD 8'hD8
`define ERASE_BULK_CMD 8'h60
`define ERASE_BULK_ALT 8'hC7
`define READ_CMD 8'h03
`define READ_FAST_CMD 8'h0B
`define READ_DUAL_CMD 8'hBB
`define READ_QUAD_CMD 8'hEB
`define READ_QDDR_CMD 8'hED
`define ADDR_BITS 6'h18
`define OP_TIME_NS 2000
`define CLK_PERIOD_NS 20
`define SCK_MAX_MHZ 50
`endif

// File: serial_flash_command_core.v
// Purpose: command front end of a serial NOR flash
// Assumes: MEM_AW of at least 10, sck well below clk/4
// Notes: link pins are sampled, not used as a clock
//
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "sflash_regs.vh"
module serial_flash_command_core #(
   parameter MEM_AW = 10,
   parameter PSECT_AW = 4,
   parameter SECT_AW = 6
) (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire cs_n,
   input wire sck,
   input wire [3:0] io_in,
   output reg [3:0] io_out,
   output reg [3:0] io_oe,
   input wire [7:0] addr,
   input wire [31:0] wdata,
   input wire we,
   input wire re,
   output reg [31:0] rdata
);
////////////////////////////////////////////////////////////////
localparam DEPTH = 1 << MEM_AW;
localparam PG = 512;
localparam [15:0] OP_CYC =
   (`OP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
localparam [2:0] S_CMD = 3'h0;
localparam [2:0] S_ADDR = 3'h1;
localparam [2:0] S_LAT = 3'h2;
localparam [2:0] S_OUT = 3'h3;
localparam [2:0] S_IN = 3'h4;
localparam [2:0] S_SKIP = 3'h5;
localparam [1:0] OP_PROG = 2'h0;
localparam [1:0] OP_ERASE = 2'h1;
localparam [1:0] OP_WREG = 2'h2;
localparam [1:0] SRC_STAT = 2'h0;
localparam [1:0] SRC_REG = 2'h1;
localparam [1:0] SRC_MEM = 2'h2;
localparam [MEM_AW-1:0] PS_MASK = (1 << PSECT_AW) - 1;
localparam [MEM_AW-1:0] SE_MASK = (1 << SECT_AW) - 1;
localparam [8:0] CFG_RST = `CTRL_RST;
////////////////////////////////////////////////////////////////
reg [7:0] mem [0:DEPTH-1];
reg [7:0] pbuf [0:PG-1];
reg cs_s1, cs_s2, cs_s3;
reg sck_s1, sck_s2, sck_s3;
reg [3:0] io_s1, io_s2;
reg [8:0] cfg_q;
reg [MEM_AW-1:0] peek_q;
reg [2:0] st_q;
reg [7:0] cmd_q;
reg [23:0] sh_q;
reg [5:0] bcnt_q;
reg [23:0] adr_q;
reg [2:0] w_q;
reg ddr_q;
reg [1:0] src_q;
reg [3:0] latc_q;
reg [7:0] obyte_q;
reg [2:0] ocnt_q;
reg [7:0] ib_q;
reg [2:0] icnt_q;
reg [8:0] pcnt_q;
reg ok_q;
reg [7:0] newcfg_q;
reg inprog_q, wlatch_q, perr_q, eerr_q;
reg busy_q, sleep_q, arm_q;
reg [1:0] op_q;
reg [15:0] opcnt_q;
reg [MEM_AW-1:0] pbase_q;
reg [MEM_AW-1:0] ebase_q;
reg [MEM_AW-1:0] emask_q;
integer i;
////////////////////////////////////////////////////////////////
function [23:0] take;
   input [23:0] s;
   input [3:0] d;
   input [2:0] w;
   begin
      case (w)
         3'h2: take = {s[21:0], d[1:0]};
         3'h4: take = {s[19:0], d};
         default: take = {s[22:0], d[0]};
      endcase
   end
endfunction

function allowed;
   input [7:0] c;
   input busy_any;
   input slp;
   begin
      if (slp) begin
         allowed = (c == `WAKE_CMD);
      end else if (busy_any) begin
         case (c)
            `STATUS1_READ_CMD, `ANY_REGISTER_READ_CMD,
            `STATUS_CLEAR_CMD, `STATUS_CLEAR_ALT,
            `RESET_ARM_CMD, `RESET_GO_CMD,
            `RESET_LEGACY_CMD: allowed = 1'b1;
            default: allowed = 1'b0;
         endcase
      end else begin
         allowed = 1'b1;
      end
   end
endfunction
////////////////////////////////////////////////////////////////
wire sel = ~cs_s2;
wire frame_end = cs_s2 & ~cs_s3;
wire rise = sck_s2 & ~sck_s3;
wire fall = ~sck_s2 & sck_s3;
// DDR address starts on a rise, so an idle fall is not data
wire in_edge = rise | (ddr_q & fall & (bcnt_q != 6'h00));
wire out_edge = fall | (ddr_q & rise);
wire inprog_all = inprog_q | busy_q | perr_q | eerr_q;
wire [7:0] sbyte = {1'b0, perr_q, eerr_q, 3'h0, wlatch_q,
   inprog_all};
// A failure landing in the same cycle as a status clear must survive it
wire op_done = busy_q & (opcnt_q == 16'h0000);
wire pfail_now = op_done & (op_q == OP_PROG) & cfg_q[`F_FPROG];
wire efail_now = op_done & (op_q == OP_ERASE) & cfg_q[`F_FERASE];
wire [7:0] cmd_next = {sh_q[6:0], io_s2[0]};
wire [23:0] adr_next = take(sh_q, io_s2, w_q);
wire [5:0] bsum = bcnt_q + {3'h0, w_q};
wire [3:0] osum = {1'b0, ocnt_q} + {1'b0, w_q};
wire [7:0] ibyte = {ib_q[6:0], io_s2[0]};
wire [8:0] pmask = cfg_q[`F_PG512] ? 9'h1FF : 9'h0FF;
wire [8:0] pidx = (adr_q[8:0] + pcnt_q) & pmask;
wire [MEM_AW-1:0] pmask_w = {{(MEM_AW-9){1'b0}}, pmask};
reg [7:0] srcbyte;
reg [7:0] ob;

always @* begin
   case (src_q)
      SRC_STAT: srcbyte = sbyte;
      SRC_REG: srcbyte = adr_q[0] ? cfg_q[7:0] : sbyte;
      default: srcbyte = mem[adr_q[MEM_AW-1:0]];
   endcase
   ob = (ocnt_q == 3'h0) ? srcbyte : obyte_q;
end
////////////////////////////////////////////////////////////////
always @(posedge clk) begin
   if (reset) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      io_s1 <= 4'h0;
      io_s2 <= 4'h0;
      cfg_q <= `CTRL_RST;
      peek_q <= {MEM_AW{1'b0}};
      st_q <= S_CMD;
      cmd_q <= 8'h00;
      sh_q <= 24'h000000;
      bcnt_q <= 6'h00;
      adr_q <= 24'h000000;
      w_q <= 3'h1;
      ddr_q <= 1'b0;
      src_q <= SRC_STAT;
      latc_q <= 4'h0;
      obyte_q <= 8'h00;
      ocnt_q <= 3'h0;
      ib_q <= 8'h00;
      icnt_q <= 3'h0;
      pcnt_q <= 9'h000;
      ok_q <= 1'b0;
      newcfg_q <= 8'h00;
      inprog_q <= 1'b0;
      wlatch_q <= 1'b0;
      perr_q <= 1'b0;
      eerr_q <= 1'b0;
      busy_q <= 1'b0;
      sleep_q <= 1'b0;
      arm_q <= 1'b0;
      op_q <= OP_PROG;
      opcnt_q <= 16'h0000;
      pbase_q <= {MEM_AW{1'b0}};
      ebase_q <= {MEM_AW{1'b0}};
      emask_q <= {MEM_AW{1'b0}};
      io_out <= 4'h0;
      io_oe <= 4'h0;
      // Array starts erased so reads are defined
      for (i = 0; i < DEPTH; i = i + 1) begin
         mem[i] <= 8'hFF;
      end
   end else if (ce) begin
      cs_s1 <= cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      sck_s1 <= sck;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      io_s1 <= io_in;
      io_s2 <= io_s1;
      if (we) begin
         case (addr)
            `OFF_CTRL: cfg_q <= wdata[8:0];
            `OFF_PEEK: peek_q <= wdata[MEM_AW-1:0];
            default: ;
         endcase
      end
      // Embedded operation timer
      if (busy_q) begin
         if (opcnt_q != 16'h0000) begin
            opcnt_q <= opcnt_q - 16'h0001;
         end else begin
            busy_q <= 1'b0;
            wlatch_q <= 1'b0;
            case (op_q)
               OP_PROG: begin
                  if (cfg_q[`F_FPROG]) begin
                     perr_q <= 1'b1;
                  end else begin
                     inprog_q <= 1'b0;
                     for (i = 0; i < PG; i = i + 1) begin
                        if (i[8:0] <= pmask) begin
                           mem[pbase_q + i[MEM_AW-1:0]] <=
                              mem[pbase_q + i[MEM_AW-1:0]]
                              & pbuf[i];
                        end
                     end
                  end
               end
               OP_ERASE: begin
                  if (cfg_q[`F_FERASE]) begin
                     eerr_q <= 1'b1;
                  end else begin
                     inprog_q <= 1'b0;
                     for (i = 0; i < DEPTH; i = i + 1) begin
                        if (((i[MEM_AW-1:0] ^ ebase_q) & ~emask_q)
                           == {MEM_AW{1'b0}}) begin
                           mem[i] <= 8'hFF;
                        end
                     end
                  end
               end
               default: begin
                  // Volatile copy takes bits 4:0 of the stored byte
                  cfg_q[4:0] <= newcfg_q[4:0];
                  inprog_q <= 1'b0;
               end
            endcase
         end
      end
      if (frame_end) begin
         // Partial frames leave ok_q low and act only by clearing arm_q
         st_q <= S_CMD;
         bcnt_q <= 6'h00;
         sh_q <= 24'h000000;
         w_q <= 3'h1;
         ddr_q <= 1'b0;
         ocnt_q <= 3'h0;
         icnt_q <= 3'h0;
         latc_q <= 4'h0;
         io_oe <= 4'h0;
         ok_q <= 1'b0;
         arm_q <= ok_q & (cmd_q == `RESET_ARM_CMD);
         if (ok_q) begin
            case (cmd_q)
               `WRITE_UNLOCK_CMD: wlatch_q <= 1'b1;
               `WRITE_LOCK_CMD: wlatch_q <= 1'b0;
               `STATUS_CLEAR_CMD, `STATUS_CLEAR_ALT: begin
                  inprog_q <= pfail_now | efail_now;
                  perr_q <= pfail_now;
                  eerr_q <= efail_now;
               end
               `RESET_GO_CMD, `RESET_LEGACY_CMD: begin
                  if (arm_q || cmd_q == `RESET_LEGACY_CMD) begin
                     inprog_q <= 1'b0;
                     wlatch_q <= 1'b0;
                     perr_q <= 1'b0;
                     eerr_q <= 1'b0;
                     busy_q <= 1'b0;
                     sleep_q <= 1'b0;
                     cfg_q[6:0] <= CFG_RST[6:0];
                  end
               end
               `DEEP_SLEEP_CMD: begin
                  if (!inprog_all) begin
                     sleep_q <= 1'b1;
                  end
               end
               `WAKE_CMD: sleep_q <= 1'b0;
               `PAGE_WRITE_CMD: begin
                  if (wlatch_q) begin
                     busy_q <= 1'b1;
                     inprog_q <= 1'b1;
                     op_q <= OP_PROG;
                     opcnt_q <= OP_CYC;
                     pbase_q <= adr_q[MEM_AW-1:0] & ~pmask_w;
                  end
               end
               `ERASE_PARAM_CMD, `ERASE_SECTOR_CMD,
               `ERASE_BULK_CMD, `ERASE_BULK_ALT: begin
                  if (wlatch_q) begin
                     busy_q <= 1'b1;
                     inprog_q <= 1'b1;
                     op_q <= OP_ERASE;
                     opcnt_q <= OP_CYC;
                     ebase_q <= adr_q[MEM_AW-1:0];
                     if (cmd_q == `ERASE_PARAM_CMD) begin
                        emask_q <= PS_MASK;
                     end else if (cmd_q == `ERASE_SECTOR_CMD) begin
                        emask_q <= SE_MASK;
                     end else begin
                        emask_q <= {MEM_AW{1'b1}};
                     end
                  end
               end
               `REG_WRITE_CMD: begin
                  if (wlatch_q && !cfg_q[`F_FREEZE]) begin
                     busy_q <= 1'b1;
                     inprog_q <= 1'b1;
                     op_q <= OP_WREG;
                     opcnt_q <= OP_CYC;
                  end
               end
               default: ;
            endcase
         end
      end else if (sel) begin
         case (st_q)
            S_CMD: begin
               if (rise) begin
                  sh_q <= {sh_q[22:0], io_s2[0]};
                  bcnt_q <= bcnt_q + 6'h01;
                  if (bcnt_q == 6'h07) begin
                     cmd_q <= cmd_next;
                     bcnt_q <= 6'h00;
                     sh_q <= 24'h000000;
                     if (!allowed(cmd_next, inprog_all, sleep_q)) begin
                        st_q <= S_SKIP;
                     end else begin
                        case (cmd_next)
                           `STATUS1_READ_CMD: begin
                              st_q <= S_OUT;
                              src_q <= SRC_STAT;
                           end
                           `ANY_REGISTER_READ_CMD: begin
                              st_q <= S_ADDR;
                              src_q <= SRC_REG;
                           end
                           `READ_CMD, `READ_FAST_CMD: begin
                              st_q <= S_ADDR;
                              src_q <= SRC_MEM;
                           end
                           `READ_DUAL_CMD: begin
                              st_q <= S_ADDR;
                              src_q <= SRC_MEM;
                              w_q <= 3'h2;
                           end
                           `READ_QUAD_CMD: begin
                              st_q <= S_ADDR;
                              src_q <= SRC_MEM;
                              w_q <= 3'h4;
                           end
                           `READ_QDDR_CMD: begin
                              st_q <= S_ADDR;
                              src_q <= SRC_MEM;
                              w_q <= 3'h4;
                              ddr_q <= 1'b1;
                           end
                           `PAGE_WRITE_CMD: begin
                              st_q <= S_ADDR;
                              pcnt_q <= 9'h000;
                              for (i = 0; i < PG; i = i + 1) begin
                                 pbuf[i] <= 8'hFF;
                              end
                           end
                           `ERASE_PARAM_CMD, `ERASE_SECTOR_CMD:
                              st_q <= S_ADDR;
                           `REG_WRITE_CMD: st_q <= S_IN;
                           default: begin
                              st_q <= S_SKIP;
                              ok_q <= 1'b1;
                           end
                        endcase
                     end
                  end
               end
            end
            S_ADDR: begin
               if (in_edge) begin
                  sh_q <= adr_next;
                  bcnt_q <= bsum;
                  if (bsum == `ADDR_BITS) begin
                     adr_q <= adr_next;
                     bcnt_q <= 6'h00;
                     latc_q <= 4'h0;
                     case (cmd_q)
                        `READ_CMD: st_q <= S_OUT;
                        `PAGE_WRITE_CMD: st_q <= S_IN;
                        `ERASE_PARAM_CMD, `ERASE_SECTOR_CMD: begin
                           st_q <= S_SKIP;
                           ok_q <= 1'b1;
                        end
                        default: begin
                           st_q <= (cfg_q[3:0] == 4'h0) ?
                              S_OUT : S_LAT;
                        end
                     endcase
                  end
               end
            end
            S_LAT: begin
               if (rise) begin
                  latc_q <= latc_q + 4'h1;
                  if (latc_q + 4'h1 == cfg_q[3:0]) begin
                     st_q <= S_OUT;
                  end
               end
            end
            S_OUT: begin
               if (out_edge) begin
                  obyte_q <= ob << w_q;
                  ocnt_q <= osum[2:0];
                  if (osum[3]) begin
                     adr_q <= adr_q + 24'h000001;
                  end
                  case (w_q)
                     3'h2: begin
                        io_out <= {2'h0, ob[7:6]};
                        io_oe <= 4'h3;
                     end
                     3'h4: begin
                        io_out <= ob[7:4];
                        io_oe <= 4'hF;
                     end
                     default: begin
                        io_out <= {2'h0, ob[7], 1'b0};
                        io_oe <= 4'h2;
                     end
                  endcase
               end
            end
            S_IN: begin
               if (rise) begin
                  ib_q <= ibyte;
                  icnt_q <= icnt_q + 3'h1;
                  if (icnt_q == 3'h7) begin
                     ok_q <= 1'b1;
                     if (cmd_q == `PAGE_WRITE_CMD) begin
                        pbuf[pidx] <= pbuf[pidx] & ibyte;
                        pcnt_q <= pcnt_q + 9'h001;
                     end else begin
                        newcfg_q <= ibyte;
                        st_q <= S_SKIP;
                     end
                  end
               end
            end
            default: ;
         endcase
      end
   end
end
////////////////////////////////////////////////////////////////
// Data stands only in the cycle after the read strobe
always @(posedge clk) begin
   if (reset) begin
      rdata <= 32'h00000000;
   end else if (ce) begin
      rdata <= 32'h00000000;
      if (re) begin
         case (addr)
            `OFF_CTRL: rdata <= {23'h000000, cfg_q};
            `OFF_STAT: rdata <= {21'h000000, arm_q, busy_q,
               sleep_q, sbyte};
            `OFF_PEEK: rdata <= {{(32-MEM_AW){1'b0}}, peek_q};
            `OFF_DATA: rdata <= {24'h000000, mem[peek_q]};
            default: rdata <= 32'h00000000;
         endcase
      end
   end
end
endmodule

// File: core_monitor.sv
// Purpose: port-level assertions for the flash command core
// Assumes: ce held high by the bench except in one short test
// Notes: bound into every core instance
`timescale 1ns/1ns
module core_monitor (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire cs_n,
   input wire sck,
   input wire [3:0] io_out,
   input wire [3:0] io_oe,
   input wire [7:0] addr,
   input wire re,
   input wire [31:0] rdata
);
   default clocking dc @(posedge clk);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////
   read_slot_a: assert property (
      $past(ce) && !$past(re) |-> rdata == 32'h0)
      else $error("read data outside its slot");
   reset_quiet_a: assert property (
      disable iff (1'b0) $past(reset) |->
      io_oe == 4'h0 && io_out == 4'h0 && rdata == 32'h0)
      else $error("outputs not quiet in reset");
   oe_release_a: assert property (
      $rose(cs_n) |-> ##5 io_oe == 4'h0)
      else $error("lines still driven after deselect");
   oe_idle_a: assert property (
      cs_n [*8] |-> io_oe == 4'h0)
      else $error("lines driven while deselected");
   oe_width_a: assert property (
      io_oe == 4'h0 || io_oe == 4'h2 || io_oe == 4'h3 || io_oe == 4'hF)
      else $error("illegal output enable set");
   out_steady_a: assert property (
      (sck && io_oe == 4'h2) [*3] |-> $stable(io_out))
      else $error("serial output moved while clock high");
   err_busy_a: assert property (
      $past(re) && $past(addr) == 8'h04 && (rdata[5] || rdata[6])
      |-> rdata[0])
      else $error("error flag without busy");
   sleep_idle_a: assert property (
      $past(re) && $past(addr) == 8'h04 && rdata[8] |-> !rdata[0])
      else $error("asleep while busy");
endmodule
bind serial_flash_command_core core_monitor mon (
   .clk(clk), .reset(reset), .ce(ce), .cs_n(cs_n), .sck(sck),
   .io_out(io_out), .io_oe(io_oe), .addr(addr), .re(re), .rdata(rdata)
);

// File: spi_host_model.sv
// Purpose: single-lane host controller for the flash link
// Assumes: clock parked low between frames
// Notes: samples returning bits on each rising edge
`timescale 1ns/1ns
module spi_host_model (
   input wire clk,
   input wire [3:0] io_w,
   output reg cs_n,
   output reg sck,
   output reg io0,
   output reg drv
);
   reg [31:0] rx;
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      io0 = 1'b0;
      drv = 1'b0;
      rx = 32'h0;
   end
   // Sends only single-lane commands, never quad command mode
   task spi(input [63:0] tx, input integer n);
      integer i;
      begin
         @(posedge clk);
         #10 cs_n = 1'b0;
         drv = 1'b1;
         for (i = 0; i < n; i = i + 1) begin
            io0 = tx[63 - i];
            #80 sck = 1'b1;
            rx = {rx[30:0], io_w[1]};
            #80 sck = 1'b0;
         end
         #80 cs_n = 1'b1;
         drv = 1'b0;
         // Gap outlasts a program or erase
         repeat (150) @(posedge clk);
      end
   endtask
endmodule

// File: tb.sv
// Purpose: self-checking bench for the flash command core
// Assumes: ce high except one clock-enable hold test, single-lane frames only
// Notes: rows hold plain frames, error paths are hand-written
`timescale 1ns/1ns
module tb;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h0;
   reg we = 1'b0;
   reg re = 1'b0;
   reg flip = 1'b0;
   reg ce = 1'b1;
   wire cs_n, sck, io0, drv;
   wire [3:0] io_out, io_oe, io_w;
   wire [31:0] rdata;
   reg [135:0] rows [0:20];
   integer num_errors = 0;
   integer check_count = 0;
   integer cyc = 0;
   integer i;
   // Undriven lines toggle so a stale value never passes
   assign io_w = (io_oe & io_out) | (~io_oe & {3'h0, drv & io0})
      | (~io_oe & ~{3'h0, drv} & {4{flip}});
   serial_flash_command_core uut (.clk(clk), .reset(reset), .ce(ce),
      .cs_n(cs_n), .sck(sck), .io_in(io_w), .io_out(io_out),
      .io_oe(io_oe), .addr(addr), .wdata(wdata), .we(we), .re(re),
      .rdata(rdata));
   spi_host_model host (.clk(clk), .io_w(io_w), .cs_n(cs_n), .sck(sck),
      .io0(io0), .drv(drv));
   ////////////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   always @(posedge clk) begin
      flip <= ~flip;
      cyc = cyc + 1;
      if (cyc == 40000) begin
         num_errors = num_errors + 1;
         give_verdict;
      end
   end
   task give_verdict;
      begin
         if (num_errors == 0 && check_count > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: saw %h expected %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         we <= 1'b1;
         @(posedge clk);
         we <= 1'b0;
      end
   endtask
   task rd(input [7:0] a, input [31:0] e);
      begin
         @(posedge clk);
         addr <= a;
         re <= 1'b1;
         @(posedge clk);
         re <= 1'b0;
         #1 chk(rdata, e);
      end
   endtask
   task sp(input [7:0] c);
      host.spi({c, 56'h0}, 8);
   endtask
   task st(input [7:0] e);
      begin
         host.spi({8'h05, 56'h0}, 16);
         chk(host.rx & 32'hFF, {24'h0, e});
      end
   endtask
   task fail_prog;
      begin
         sp(8'h06);
         host.spi({8'h02, 56'h0}, 40);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      rows[0] = {64'h0600000000000000, 8'h08, 32'h0, 32'h0};
      rows[1] = {64'h0500000000000000, 8'h10, 32'hFF, 32'h02};
      rows[2] = {64'h0400000000000000, 8'h08, 32'h0, 32'h0};
      rows[3] = {64'h0500000000000000, 8'h10, 32'hFF, 32'h00};
      rows[4] = rows[0];
      rows[5] = {64'h020003FE12340000, 8'h30, 32'h0, 32'h0};
      rows[6] = rows[3];
      rows[7] = {64'h030003FE00000000, 8'h40, 32'hFFFFFFFF, 32'h1234FFFF};
      rows[8] = {64'h0B0003FF00000000, 8'h38, 32'hFFFF, 32'h34FF};
      rows[9] = rows[0];
      rows[10] = {64'h020003FEF0000000, 8'h28, 32'h0, 32'h0};
      rows[11] = {64'h030003FE00000000, 8'h28, 32'hFF, 32'h10};
      rows[12] = rows[0];
      rows[13] = {64'h200003FE00000000, 8'h20, 32'h0, 32'h0};
      rows[14] = {64'h030003FE00000000, 8'h30, 32'hFFFF, 32'hFFFF};
      rows[15] = {64'h0200000000000000, 8'h28, 32'h0, 32'h0};
      rows[16] = {64'h0300000000000000, 8'h28, 32'hFF, 32'hFF};
      rows[17] = {64'h0600000000000000, 8'h05, 32'h0, 32'h0};
      rows[18] = rows[3];
      rows[19] = {64'h6500000100000000, 8'h30, 32'hFF, 32'h08};
      rows[20] = {64'h6500000000000000, 8'h30, 32'hFF, 32'h00};
      repeat (12) @(posedge clk);
      reset <= 1'b0;
      rd(8'h00, 32'h008);
      rd(8'h04, 32'h0);
      rd(8'h0C, 32'hFF);
      rd(8'h10, 32'h0);
      wr(8'h04, 32'hFFFF);
      rd(8'h04, 32'h0);
      for (i = 0; i < 21; i = i + 1) begin
         host.spi(rows[i][135:72], rows[i][71:64]);
         if (rows[i][63:32] != 32'h0)
            chk(host.rx & rows[i][63:32], rows[i][31:0]);
      end
      wr(8'h00, 32'h024);
      rd(8'h00, 32'h024);
      fail_prog;
      st(8'h41);
      rd(8'h04, 32'h041);
      sp(8'h06);
      st(8'h41);
      sp(8'h30);
      sp(8'h04);
      st(8'h00);
      wr(8'h00, 32'h048);
      sp(8'h06);
      host.spi({8'hD8, 56'h0}, 32);
      st(8'h21);
      sp(8'h82);
      st(8'h00);
      wr(8'h00, 32'h1A8);
      fail_prog;
      sp(8'h66);
      rd(8'h04, 32'h441);
      sp(8'h99);
      st(8'h00);
      rd(8'h00, 32'h188);
      wr(8'h00, 32'h028);
      fail_prog;
      sp(8'hB9);
      rd(8'h04, 32'h041);
      sp(8'hF0);
      st(8'h00);
      sp(8'hB9);
      rd(8'h04, 32'h100);
      sp(8'h06);
      sp(8'hAB);
      rd(8'h04, 32'h0);
      sp(8'h06);
      host.spi({8'h01, 8'h15, 48'h0}, 16);
      rd(8'h00, 32'h015);
      st(8'h00);
      ce <= 1'b0;
      wr(8'h00, 32'h00F);
      ce <= 1'b1;
      rd(8'h00, 32'h015);
      wr(8'h00, 32'h003);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      rd(8'h00, 32'h008);
      give_verdict;
   end
endmodule
